/* common/fsbb_defs.svh */
`ifndef FSBB_DEFS_SVH
`define FSBB_DEFS_SVH

// system clock rate in hertz
`define FSBB_CLK_HZ 10000000

// the two selectable switching rates in hertz
`define FSBB_RATE_LO_HZ 250000
`define FSBB_RATE_HI_HZ 420000

// switching_rate_select codes
`define FSBB_SEL_LO 2'b00
`define FSBB_SEL_HI 2'b01

// period lengths in system clock cycles
`define FSBB_LO_CYC (`FSBB_CLK_HZ / `FSBB_RATE_LO_HZ)
`define FSBB_HI_CYC (`FSBB_CLK_HZ / `FSBB_RATE_HI_HZ)

// fixed middle phase of the buck-boost pattern, percent of period
`define FSBB_BB_MID_PCT 75

// dither span for the higher rate, percent of period
`define FSBB_DITHER_PCT 11
`define FSBB_DITHER_CYC ((`FSBB_HI_CYC * `FSBB_DITHER_PCT) / 100)

// non-overlap time between partner switches, rounded up to cycles
`define FSBB_DEADTIME_NS 100
`define FSBB_DEADTIME_CYC ((`FSBB_DEADTIME_NS * (`FSBB_CLK_HZ / 1000000) + 999) / 1000)

`endif

/* common/fsbb_pkg.sv */
package fsbb_pkg;

    // operating mode, gray along buck -> buck-boost -> boost
    typedef enum logic [1:0] {
        FSBB_MODE_BUCK  = 2'b00,
        FSBB_MODE_BB    = 2'b01,
        FSBB_MODE_BOOST = 2'b11
    } fsbb_mode_t;

    // phase inside one switching period, gray along idle -> on -> mid -> off
    typedef enum logic [1:0] {
        FSBB_PH_IDLE = 2'b00,
        FSBB_PH_ON   = 2'b01,
        FSBB_PH_MID  = 2'b11,
        FSBB_PH_OFF  = 2'b10
    } fsbb_phase_t;

    // analog supervisor flags that steer mode changes
    typedef struct packed {
        logic near_min_off; // buck off time close to its minimum
        logic near_min_on;  // boost on time close to its minimum
        logic vin_high;     // input about 10% above output
        logic vin_low;      // input about 10% below output
    } fsbb_mode_req_t;

endpackage : fsbb_pkg

/* hdl/fsbb_deadtime.sv */
`timescale 1ns/1ps
`include "fsbb_defs.svh"

// one half-bridge driver with break-before-make
module fsbb_deadtime
    import fsbb_pkg::*;
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    // command
    input wire logic en_i,
    input wire logic hi_cmd_i,
    // gate drives
    output logic hi_o,
    output logic lo_o
);

    localparam logic [3:0] DT_CYC = 4'(`FSBB_DEADTIME_CYC);

    logic hi_reg; // high side gate
    logic lo_reg; // low side gate
    logic [3:0] dt_reg; // non-overlap countdown

    // requested gate levels, both off while disabled
    wire want_hi = en_i & hi_cmd_i;
    wire want_lo = en_i & ~hi_cmd_i;
    // a gate that is on but no longer wanted
    wire wrong = (hi_reg & ~want_hi) | (lo_reg & ~want_lo);
    wire both_off = ~hi_reg & ~lo_reg;
    wire dt_done = (dt_reg == 4'h0);

    // break first, wait, then make; the partner never sees an overlap
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            hi_reg <= 1'b0;
            lo_reg <= 1'b0;
            dt_reg <= DT_CYC;
        end else if (wrong) begin
            hi_reg <= 1'b0;
            lo_reg <= 1'b0;
            dt_reg <= DT_CYC;
        end else if (both_off && !dt_done) begin
            dt_reg <= dt_reg - 4'h1;
        end else if (both_off) begin
            hi_reg <= want_hi;
            lo_reg <= want_lo;
        end
    end

    assign hi_o = hi_reg;
    assign lo_o = lo_reg;

endmodule : fsbb_deadtime

/* hdl/fsbb_pwm.sv */
`timescale 1ns/1ps
`include "fsbb_defs.svh"

module fsbb_pwm
    import fsbb_pkg::*;
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    // configuration
    input wire logic [1:0] switching_rate_select_i,
    // current comparator, high when switch current hits demand
    input wire logic cur_at_demand_i,
    // mode steering flags
    input wire fsbb_mode_req_t mode_req_i,
    // power switch drives, high turns the switch on
    output logic input_high_switch_o,
    output logic input_low_switch_o,
    output logic output_low_switch_o,
    output logic output_high_switch_o,
    // status
    output fsbb_mode_t mode_o,
    output logic period_start_o
);

    // period lengths held at counter width
    localparam logic [5:0] LO_CYC = 6'(`FSBB_LO_CYC);
    localparam logic [5:0] HI_CYC = 6'(`FSBB_HI_CYC);
    localparam logic [5:0] DITH_CYC = 6'(`FSBB_DITHER_CYC);
    // dither sweeps from HI_CYC-DITH_CYC to HI_CYC+DITH_CYC
    localparam logic [5:0] DITH_TOP = 6'(2 * `FSBB_DITHER_CYC);
    localparam logic [7:0] MID_PCT = 8'(`FSBB_BB_MID_PCT);

    // state
    logic [5:0] cnt_reg; // cycle within the period
    logic [5:0] len_reg; // length of the running period
    logic [5:0] dith_reg; // sawtooth dither step
    logic [5:0] mid_reg; // remaining cycles of the middle phase
    logic started_reg; // first period has begun
    logic start_p_reg; // period start pulse
    fsbb_mode_t mode_reg; // operating mode
    fsbb_phase_t phase_reg; // phase inside the period

    // next-state values
    logic [5:0] cnt_next;
    logic [5:0] len_next;
    logic [5:0] dith_next;
    logic [5:0] mid_next;
    fsbb_mode_t mode_next;
    fsbb_phase_t phase_next;

    // bridge commands: index 0 input bridge, 1 output bridge
    logic [1:0] br_hi_cmd;
    logic [1:0] br_hi;
    logic [1:0] br_lo;

    // end of the running period, the next edge starts a new one
    wire tick = (cnt_reg == len_reg - 6'h1);

    // rate decode; reserved codes fall back to the low rate
    wire sel_hi = (switching_rate_select_i == `FSBB_SEL_HI);

    // dithered high-rate length, spreads the spectrum of the high rate
    wire [5:0] hi_len = HI_CYC - DITH_CYC + dith_reg;

    // next period length chosen at each boundary
    wire [5:0] new_len = sel_hi ? hi_len : LO_CYC;

    // middle phase length: 75 percent of the running period
    wire [13:0] mid_prod = {8'h00, len_reg} * {6'h00, MID_PCT};
    wire [5:0] mid_len = 6'(mid_prod / 14'd100);

    // comparator trip while the controlled switch conducts
    wire trip = (phase_reg == FSBB_PH_ON) && cur_at_demand_i;

    // mid phase runs out
    wire mid_done = (mid_reg == 6'h0);

    // gates are driven only once switching has begun
    wire drive_en = started_reg;

    // period counter and length
    always_comb begin
        cnt_next = tick ? 6'h0 : cnt_reg + 6'h1;
        len_next = tick ? new_len : len_reg;
    end

    // dither advances once per period, wraps after the top step
    always_comb begin
        if (tick && sel_hi) begin
            dith_next = (dith_reg >= DITH_TOP) ? 6'h0 : dith_reg + 6'h1;
        end else if (tick) begin
            dith_next = 6'h0; // low rate runs undithered
        end else begin
            dith_next = dith_reg;
        end
    end

    // mode selection, only at a period boundary so a period
    // never mixes two patterns
    always_comb begin
        mode_next = mode_reg;
        if (tick) begin
            unique case (mode_reg)
                FSBB_MODE_BUCK: begin
                    // off time about to clip: hand over to buck-boost
                    if (mode_req_i.near_min_off) begin
                        mode_next = FSBB_MODE_BB;
                    end
                end
                FSBB_MODE_BB: begin
                    // buck wins when both flags show, input clearly high
                    if (mode_req_i.vin_high) begin
                        mode_next = FSBB_MODE_BUCK;
                    end else if (mode_req_i.vin_low) begin
                        mode_next = FSBB_MODE_BOOST;
                    end
                end
                FSBB_MODE_BOOST: begin
                    // on time about to clip: hand over to buck-boost
                    if (mode_req_i.near_min_on) begin
                        mode_next = FSBB_MODE_BB;
                    end
                end
                default: begin
                    // unused code, recover through buck-boost
                    mode_next = FSBB_MODE_BB;
                end
            endcase
        end
    end

    // phase sequencing inside a period
    always_comb begin
        phase_next = phase_reg;
        mid_next = mid_reg;
        if (tick) begin
            // every boundary re-arms the controlled switch
            phase_next = FSBB_PH_ON;
        end else begin
            unique case (phase_reg)
                FSBB_PH_IDLE: begin
                    // waiting for the first boundary after reset
                    phase_next = FSBB_PH_IDLE;
                end
                FSBB_PH_ON: begin
                    if (trip && mode_reg == FSBB_MODE_BB) begin
                        // buck-boost: second pair for a fixed share;
                        // the count ends at zero, so load one less
                        phase_next = FSBB_PH_MID;
                        mid_next = mid_len - 6'h1;
                    end else if (trip) begin
                        phase_next = FSBB_PH_OFF;
                    end
                end
                FSBB_PH_MID: begin
                    // cut short at the boundary if the share overruns
                    if (mid_done) begin
                        phase_next = FSBB_PH_OFF;
                    end else begin
                        mid_next = mid_reg - 6'h1;
                    end
                end
                FSBB_PH_OFF: begin
                    // no retrigger inside the period
                    phase_next = FSBB_PH_OFF;
                end
            endcase
        end
    end

    // pattern decode into half-bridge high-side commands
    always_comb begin
        br_hi_cmd = 2'b00;
        unique case (mode_reg)
            FSBB_MODE_BUCK: begin
                // input high on, then input low; output high held on
                br_hi_cmd[0] = (phase_reg == FSBB_PH_ON);
                br_hi_cmd[1] = 1'b1;
            end
            FSBB_MODE_BOOST: begin
                // output low on, then output high; input high held on
                br_hi_cmd[0] = 1'b1;
                br_hi_cmd[1] = (phase_reg != FSBB_PH_ON);
            end
            FSBB_MODE_BB: begin
                // on: in-high/out-low, mid: in-high/out-high,
                // off: in-low/out-high
                br_hi_cmd[0] = (phase_reg != FSBB_PH_OFF);
                br_hi_cmd[1] = (phase_reg != FSBB_PH_ON);
            end
            default: begin
                // unused mode code: both bridges to low side
                br_hi_cmd = 2'b00;
            end
        endcase
    end

    // counter, length and dither registers
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            cnt_reg <= 6'h00;
            len_reg <= LO_CYC;
            dith_reg <= 6'h00;
        end else begin
            cnt_reg <= cnt_next;
            len_reg <= len_next;
            dith_reg <= dith_next;
        end
    end

    // mode, phase and middle-phase registers
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            mode_reg <= FSBB_MODE_BUCK;
            phase_reg <= FSBB_PH_IDLE;
            mid_reg <= 6'h00;
        end else begin
            mode_reg <= mode_next;
            phase_reg <= phase_next;
            mid_reg <= mid_next;
        end
    end

    // start flag and period pulse
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            started_reg <= 1'b0;
            start_p_reg <= 1'b0;
        end else begin
            started_reg <= started_reg | tick;
            start_p_reg <= tick;
        end
    end

    // one driver per half-bridge; deadtime delays each gate
    // by a few cycles, traded for a hard guarantee against overlap
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_bridge
            fsbb_deadtime u_dt (
                .clk_sys_i(clk_sys_i),
                .sys_rst_i(sys_rst_i),
                .en_i(drive_en),
                .hi_cmd_i(br_hi_cmd[gi]),
                .hi_o(br_hi[gi]),
                .lo_o(br_lo[gi])
            );
        end
    endgenerate

    // outputs, all straight from flip-flops
    assign input_high_switch_o = br_hi[0];
    assign input_low_switch_o = br_lo[0];
    assign output_high_switch_o = br_hi[1];
    assign output_low_switch_o = br_lo[1];
    assign mode_o = mode_reg;
    assign period_start_o = start_p_reg;

endmodule : fsbb_pwm

/* dv/fsbb_pwm_monitor.sv */
`timescale 1ns/1ps
// gate sequencing checks beside the pwm core
module fsbb_pwm_monitor
    import fsbb_pkg::*;
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    // inputs
    input wire logic [1:0] switching_rate_select_i,
    input wire logic cur_at_demand_i,
    // outputs
    input wire logic input_high_switch_o,
    input wire logic input_low_switch_o,
    input wire logic output_low_switch_o,
    input wire logic output_high_switch_o,
    input wire fsbb_mode_t mode_o,
    input wire logic period_start_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);
    wire logic sa = input_high_switch_o;
    wire logic sb = input_low_switch_o;
    wire logic sc = output_low_switch_o;
    wire logic sd = output_high_switch_o;
    wire logic buck = (mode_o == FSBB_MODE_BUCK);
    logic [6:0] len_reg; // cycles since last period start
    logic sel_reg; // high rate code at the previous edge
    logic hi_reg; // running period uses the high rate
    logic seen_reg; // a period start seen since reset
    // length tracker; the rate seen at the tick belongs to the period it launches
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            len_reg <= 7'h00;
            seen_reg <= 1'b0;
        end else begin
            len_reg <= period_start_o ? 7'h01 : len_reg + 7'h01;
            seen_reg <= seen_reg | period_start_o;
        end
        sel_reg <= (switching_rate_select_i == 2'h1);
        if (period_start_o) begin
            hi_reg <= sel_reg;
        end
    end
    property p_in_excl; !(sa && sb); endproperty
    a_in_excl: assert property (p_in_excl) else $error("input bridge overlap");
    property p_out_excl; !(sc && sd); endproperty
    a_out_excl: assert property (p_out_excl) else $error("output bridge overlap");
    property p_gap; $fell(sa) |-> !sb [*2]; endproperty
    a_gap: assert property (p_gap) else $error("no gap before low side");
    property p_rst_off;
        disable iff (1'b0) sys_rst_i |=> !(sa || sb || sc || sd || period_start_o) && buck;
    endproperty
    a_rst_off: assert property (p_rst_off) else $error("drive during reset");
    property p_len;
        period_start_o && seen_reg |->
            (hi_reg ? (len_reg inside {[7'h15:7'h19]}) : (len_reg == 7'h28));
    endproperty
    a_len: assert property (p_len) else $error("period length wrong");
    property p_cap; len_reg <= (seen_reg ? 7'h28 : 7'h2a); endproperty
    a_cap: assert property (p_cap) else $error("period overran");
    property p_trip; buck && $stable(mode_o) && sa && cur_at_demand_i |-> ##[1:3] !sa; endproperty
    a_trip: assert property (p_trip) else $error("no turn-off at demand");
    property p_stay_off; $fell(sa) && buck |-> !sa until period_start_o; endproperty
    a_stay_off: assert property (p_stay_off) else $error("on again in period");
    property p_step;
        $changed(mode_o) |-> mode_o == FSBB_MODE_BB || $past(mode_o) == FSBB_MODE_BB;
    endproperty
    a_step: assert property (p_step) else $error("mode skipped a step");
    property p_bb_mid; mode_o == FSBB_MODE_BB && $rose(sd) |-> sa; endproperty
    a_bb_mid: assert property (p_bb_mid) else $error("middle pair wrong");
    c_bb: cover property (mode_o == FSBB_MODE_BB && $rose(sd));
    c_boost: cover property (mode_o == FSBB_MODE_BOOST && $fell(sc));
    c_hi: cover property (period_start_o && seen_reg && hi_reg);
endmodule : fsbb_pwm_monitor

/* dv/fsbb_plant.sv */
`timescale 1ns/1ps
// current comparator model driven by the four switch drives
module fsbb_plant (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    // bench control
    input wire logic ctl_out_i, // watch output low switch, else input high
    input wire logic [3:0] demand_i, // on-cycles until demand is reached
    input wire logic glitch_i, // stray pulses early in the off time
    // switch drives
    input wire logic input_high_switch_i,
    input wire logic input_low_switch_i,
    input wire logic output_low_switch_i,
    input wire logic output_high_switch_i,
    // comparator
    output logic cur_at_demand_o
);
    wire logic on = ctl_out_i ? output_low_switch_i : input_high_switch_i;
    wire logic partner = ctl_out_i ? output_high_switch_i : input_low_switch_i;
    logic [5:0] on_reg; // cycles the controlled switch conducted
    logic [5:0] off_reg; // cycles its partner conducted
    // ramps restart whenever a switch opens
    always_ff @(posedge clk_sys_i) begin
        on_reg <= (on && !sys_rst_i) ? on_reg + 6'h01 : 6'h00;
        off_reg <= (partner && !sys_rst_i) ? off_reg + 6'h01 : 6'h00;
    end
    // stray pulses stay clear of the next period head, which would trip for real
    assign cur_at_demand_o = (on && on_reg >= {2'h0, demand_i})
        || (glitch_i && off_reg != 6'h00 && off_reg < 6'h04);
endmodule : fsbb_plant

/* dv/tb.sv */
`timescale 1ns/1ps
`include "fsbb_defs.svh"
module tb;
    import fsbb_pkg::*;
    logic clk_sys_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [1:0] rate_sel = 2'h0; // rate code
    fsbb_mode_req_t mode_req = '0; // supervisor flags
    logic ctl_out = 1'b0; // plant watches output low switch
    logic [3:0] demand = 4'h5; // on-cycles until trip
    logic glitch = 1'b0; // stray comparator pulses
    logic cur, sa, sb, sc, sd, pstart;
    fsbb_mode_t mode;
    fsbb_mode_t exp_mode = FSBB_MODE_BUCK; // bench copy of the mode walk
    int n_errors = 0;
    int samples_checked = 0;
    int cyc = 0;
    // mode walk: flags, watched switch, periods measured
    logic [3:0] walk_req [4] = '{4'h8, 4'h1, 4'h4, 4'h3};
    logic walk_ctl [4] = '{1'b1, 1'b1, 1'b1, 1'b0};
    int walk_win [4] = '{2, 2, 2, 2};
    logic [1:0] rates [3] = '{2'h1, 2'h2, 2'h0};
    fsbb_pwm uut (.clk_sys_i, .sys_rst_i, .switching_rate_select_i(rate_sel),
        .cur_at_demand_i(cur), .mode_req_i(mode_req), .input_high_switch_o(sa),
        .input_low_switch_o(sb), .output_low_switch_o(sc), .output_high_switch_o(sd),
        .mode_o(mode), .period_start_o(pstart));
    fsbb_plant u_plant (.clk_sys_i, .sys_rst_i, .ctl_out_i(ctl_out), .demand_i(demand),
        .glitch_i(glitch), .input_high_switch_i(sa), .input_low_switch_i(sb),
        .output_low_switch_i(sc), .output_high_switch_i(sd), .cur_at_demand_o(cur));
    initial begin
        forever #50 clk_sys_i = ~clk_sys_i;
    end
    // hang guard, far above the roughly 1800 cycles needed
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            $display("ERROR at %0t: run hung", $time);
            stop_test();
        end
    end
    task automatic check(input logic ok, input string what);
        samples_checked++;
        if (ok !== 1'b1) begin
            n_errors++;
            $display("ERROR at %0t: %s", $time, what);
        end
    endtask : check
    task automatic stop_test();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : stop_test
    // mode steps only one place per boundary
    function automatic fsbb_mode_t next_mode(fsbb_mode_t m, fsbb_mode_req_t r);
        if (m == FSBB_MODE_BUCK)
            return r.near_min_off ? FSBB_MODE_BB : m;
        if (m == FSBB_MODE_BOOST)
            return r.near_min_on ? FSBB_MODE_BB : m;
        return r.vin_high ? FSBB_MODE_BUCK : (r.vin_low ? FSBB_MODE_BOOST : m);
    endfunction : next_mode
    task automatic wait_ps();
        int i;
        i = 0;
        do begin
            @(negedge clk_sys_i);
            i++;
        end while (pstart !== 1'b1 && i < 60);
        check(pstart === 1'b1, "period start missing");
        exp_mode = next_mode(exp_mode, mode_req);
    endtask : wait_ps
    // whole-period on-times: trip after demand, two 2-cycle gaps
    task automatic window(input int k);
        int cnt [5];
        int n;
        int w;
        int mid;
        logic ok;
        repeat (k) begin
            cnt = '{default: 0};
            do begin
                cnt[0] += int'(sa === 1'b1);
                cnt[1] += int'(sb === 1'b1);
                cnt[2] += int'(sc === 1'b1);
                cnt[3] += int'(sd === 1'b1);
                cnt[4]++;
                @(negedge clk_sys_i);
            end while (pstart !== 1'b1 && cnt[4] < 60);
            n = int'(demand);
            w = cnt[4];
            // middle pair holds a fixed share of the period
            mid = (w * `FSBB_BB_MID_PCT) / 100;
            // the period just counted ran in the mode chosen at its own start
            if (exp_mode == FSBB_MODE_BB)
                ok = cnt[2] == n + 2 && cnt[3] == w - 6 - n && cnt[0] == n + mid + 2
                    && cnt[1] == w - n - mid - 6;
            else
                ok = ctl_out ? (cnt[2] == n + 2 && cnt[3] == w - 6 - n && cnt[0] == w && cnt[1] == 0)
                    : (cnt[0] == n + 2 && cnt[1] == w - 6 - n && cnt[2] == 0 && cnt[3] == w);
            check(ok, "gate on-times");
            check(rate_sel == 2'h1 ? (w >= 21 && w <= 25) : w == 40, "period length");
            exp_mode = next_mode(exp_mode, mode_req);
        end
    endtask : window
    initial begin
        int n;
        logic idle;
        void'($urandom(40474));
        repeat (11) @(posedge clk_sys_i);
        // look between edges, then release on the twelfth edge
        @(negedge clk_sys_i);
        check({sa, sb, sc, sd, pstart} === 5'h00 && mode === FSBB_MODE_BUCK, "reset");
        @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        n = 0;
        idle = 1'b1;
        while (pstart !== 1'b1 && n < 60) begin
            @(negedge clk_sys_i);
            n++;
            idle = idle && ({sa, sb, sc, sd} === 4'h0);
        end
        check(idle && n >= 39 && n <= 42, "start-up");
        $display("test reset done");
        wait_ps();
        window(3);
        $display("test buck done");
        @(posedge clk_sys_i);
        glitch <= 1'b1;
        wait_ps();
        window(2);
        $display("test stray trip done");
        foreach (rates[i]) begin
            @(posedge clk_sys_i);
            glitch <= 1'b0;
            rate_sel <= rates[i];
            demand <= 4'($urandom_range(12, 1));
            repeat (2) wait_ps();
            window(3);
            $display("test rate %0d done", rates[i]);
        end
        foreach (walk_req[i]) begin
            @(posedge clk_sys_i);
            mode_req <= walk_req[i];
            ctl_out <= walk_ctl[i];
            // short on-time keeps the buck-boost off pair inside the period
            demand <= 4'h2;
            repeat (3) wait_ps();
            repeat (3) @(negedge clk_sys_i);
            check(mode === exp_mode, "mode");
            wait_ps();
            window(walk_win[i]);
            $display("test mode step %0d done", i);
        end
        stop_test();
    end
endmodule : tb
bind fsbb_pwm fsbb_pwm_monitor u_mon (.clk_sys_i, .sys_rst_i, .switching_rate_select_i,
    .cur_at_demand_i, .input_high_switch_o, .input_low_switch_o, .output_low_switch_o,
    .output_high_switch_o, .mode_o, .period_start_o);
